// >>> logic/dilp_consts.svh
// constants for the dram init and pattern-load block
`ifndef DILP_CONSTS_SVH
`define DILP_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define DILP_CLK_PERIOD_NS    100
`define DILP_CORE_SETTLE_US   500
`define DILP_SETTLE_CYC       ((`DILP_CORE_SETTLE_US * 1000 + `DILP_CLK_PERIOD_NS - 1) / `DILP_CLK_PERIOD_NS)
`define DILP_RST_HI_MIN       2'h2
`define DILP_ID_MAX           6'h3F

// ----------------------------------------------------------------
// holding register and core words
// ----------------------------------------------------------------
`define DILP_BYTE_W           8
`define DILP_WORD_W           16
`define DILP_NUM_WORDS        16
`define DILP_COL_W            256
`define DILP_BYTES_PER_COL    5'h1F
`define DILP_ROW_W            11
`define DILP_FIFO_DEPTH       16

// ----------------------------------------------------------------
// width field codes and reset value
// ----------------------------------------------------------------
`define DILP_WIDTH_X4         3'h2
`define DILP_WIDTH_X8         3'h3
`define DILP_WIDTH_X16        3'h4
`define DILP_WIDTH_RESET      3'h4
`define DILP_MASK_ALL         16'hFFFF
`define DILP_MASK_LO8         16'h00FF
`define DILP_MASK_HI8         16'hFF00
`define DILP_MASK_Q4          16'h000F

`endif

// >>> logic/dilp_pkg.sv
// types for the dram init and pattern-load block
package dilp_pkg;

  // ----------------------------------------------------------------
  // serial init sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DILP_S_IDLE    = 2'b00,
    DILP_S_RST_HI  = 2'b01,
    DILP_S_MEASURE = 2'b10,
    DILP_S_DONE    = 2'b11
  } dilp_state_t;

endpackage : dilp_pkg

// >>> logic/dilp_fifo.sv
// synchronous valid/ready fifo built from flip-flops
`timescale 1ns/1ps
module dilp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
    end
  end

endmodule : dilp_fifo

// >>> logic/dilp_top.sv
// dram init sequencer, chain id capture and serial pattern-load holding register
// What this block does
// - after power-up and the core settle time, enter the low-power state
// - serial reset sampled high puts the device into the same low-power state
// - after serial reset control registers hold defaults; the chain id is valid once chain input is seen low
// - conditioning activates take rows from bank row counters stepping one row per increment
// - each pattern-load packet shifts one byte, eight bit positions, into holding
// - one full packet sequence fills exactly one column in the holding register
// - sub-columns per column equal native width over programmed width
// - each column write with a column loaded commits the sub-column chosen by the sub-column select
// - loaded words 0..15 land on core words 15,7,11,3,13,5,9,1,0,8,4,12,2,10,6,14
// - x16 writes all words; x8 and x4 write halves or quarters by select bits
// - serial inputs sampled on falling serial clock; defaults after first reset sample
// - one serial cycle after chain input seen low, drive chain output low
// - count cycles from reset release to chain input low as six-bit id
`timescale 1ns/1ps
`include "dilp_consts.svh"
module dilp_top
  import dilp_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `DILP_SETTLE_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         serial_clk,
  input  wire logic         serial_reset,
  input  wire logic         chain_input,
  output logic              chain_output,
  output logic [5:0]        chain_position_id,
  output logic              id_valid,
  output logic              low_power,
  input  wire logic         powerdown_exit,
  input  wire logic         width_wr,
  input  wire logic [2:0]   width_cfg,
  output logic [2:0]        programmed_width,
  input  wire logic         refresh_activate_increment,
  output logic [10:0]       bank_row_counter,
  input  wire logic         pattern_valid,
  input  wire logic [7:0]   pattern_byte,
  output logic              pattern_ready,
  output logic              column_loaded,
  input  wire logic         col_wr_valid,
  input  wire logic [3:0]   subcolumn_select,
  output logic              core_wr_valid,
  output logic [15:0]       core_wr_enable,
  output logic [255:0]      core_word
);

  // ----------------------------------------------------------------
  // power-on settle
  // ----------------------------------------------------------------
  logic [31:0] settle_cnt_q;
  logic        settle_done_q;
  wire         settle_hit;

  assign settle_hit = !settle_done_q && (settle_cnt_q == SETTLE_CYCLES - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_cnt_q  <= '0;
      settle_done_q <= 1'b0;
    end else if (!settle_done_q) begin
      settle_cnt_q  <= settle_cnt_q + 32'h1;
      settle_done_q <= settle_hit;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and falling serial clock detect
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  wire        sck_s;
  wire        rst_s;
  wire        chain_s;
  wire        fall;

  assign sck_s   = sync2_q[2];
  assign rst_s   = sync2_q[1];
  assign chain_s = sync2_q[0];
  assign fall    = sck_prev_q && !sck_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q    <= 3'h0;
      sync2_q    <= 3'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {serial_clk, serial_reset, chain_input};
      sync2_q    <= sync1_q;
      sck_prev_q <= sck_s;
    end
  end

  // ----------------------------------------------------------------
  // serial reset and chain id measurement
  // ----------------------------------------------------------------
  dilp_state_t state_q;
  logic [1:0]  hi_cnt_q;
  logic [5:0]  meas_cnt_q;
  logic        drop_pending_q;
  wire         reset_edge;
  wire         release_edge;
  wire         meas_hit;
  wire  [5:0]  id_now;

  assign reset_edge   = fall && rst_s;
  assign release_edge = fall && !rst_s && (state_q == DILP_S_RST_HI)
                        && (hi_cnt_q >= `DILP_RST_HI_MIN);
  assign meas_hit     = !chain_s && (release_edge || (fall && state_q == DILP_S_MEASURE));
  assign id_now       = release_edge ? 6'h00 :
                        (meas_cnt_q == `DILP_ID_MAX) ? `DILP_ID_MAX : meas_cnt_q + 6'h01;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q           <= DILP_S_IDLE;
      hi_cnt_q          <= 2'h0;
      meas_cnt_q        <= 6'h00;
      drop_pending_q    <= 1'b0;
      chain_output      <= 1'b0;
      chain_position_id <= 6'h00;
      id_valid          <= 1'b0;
    end else if (reset_edge) begin
      if (state_q == DILP_S_RST_HI) begin
        chain_output <= 1'b1;
      end
      state_q        <= DILP_S_RST_HI;
      hi_cnt_q       <= (hi_cnt_q == 2'h3) ? 2'h3 : hi_cnt_q + 2'h1;
      id_valid       <= 1'b0;
      drop_pending_q <= 1'b0;
    end else if (fall) begin
      hi_cnt_q <= 2'h0;
      case (state_q)
        DILP_S_RST_HI: begin
          chain_output <= 1'b1;
          meas_cnt_q   <= 6'h00;
          state_q      <= release_edge ? DILP_S_MEASURE : DILP_S_IDLE;
        end
        DILP_S_MEASURE: begin
          meas_cnt_q <= id_now;
        end
        DILP_S_DONE: begin
          if (drop_pending_q) begin
            chain_output   <= 1'b0;
            drop_pending_q <= 1'b0;
          end
        end
        default: begin
        end
      endcase
      if (meas_hit) begin
        chain_position_id <= id_now;
        id_valid          <= 1'b1;
        drop_pending_q    <= 1'b1;
        state_q           <= DILP_S_DONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // low-power state, width register, bank row counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_power        <= 1'b0;
      programmed_width <= `DILP_WIDTH_RESET;
      bank_row_counter <= '0;
    end else if (reset_edge) begin
      low_power        <= 1'b1;
      programmed_width <= `DILP_WIDTH_RESET;
      bank_row_counter <= '0;
    end else begin
      if (settle_hit) begin
        low_power <= 1'b1;
      end else if (powerdown_exit) begin
        low_power <= 1'b0;
      end
      if (width_wr) begin
        programmed_width <= width_cfg;
      end
      if (refresh_activate_increment) begin
        bank_row_counter <= bank_row_counter + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pattern byte fifo and holding register
  // ----------------------------------------------------------------
  logic [255:0] hold_q;
  logic [4:0]   byte_cnt_q;
  wire          fifo_valid;
  wire  [7:0]   fifo_data;
  wire          drain_ready;
  wire          take;

  // a column write in flight or a serial reset stalls the shifter
  assign drain_ready = !col_wr_valid && !reset_edge;
  assign take        = fifo_valid && drain_ready;

  dilp_fifo #(
    .WIDTH (`DILP_BYTE_W),
    .DEPTH (`DILP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (pattern_valid),
    .in_ready  (pattern_ready),
    .in_data   (pattern_byte),
    .out_valid (fifo_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_data)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_q        <= '0;
      byte_cnt_q    <= 5'h00;
      column_loaded <= 1'b0;
    end else if (reset_edge) begin
      byte_cnt_q    <= 5'h00;
      column_loaded <= 1'b0;
    end else if (take) begin
      hold_q        <= {hold_q[247:0], fifo_data};
      byte_cnt_q    <= byte_cnt_q + 5'h01;
      column_loaded <= (byte_cnt_q == `DILP_BYTES_PER_COL);
    end
  end

  // ----------------------------------------------------------------
  // column commit: word map and sub-column mask
  // ----------------------------------------------------------------
  wire [255:0] mapped;
  wire [15:0]  mask_x8;
  wire [15:0]  mask_x4;
  wire [15:0]  wr_mask;
  wire         commit;

  // even core word c takes loaded word 8 + bitrev3(c[3:1]), odd c takes 7 - bitrev3(c[3:1])
  // loaded word 0 sits at the top of hold
  for (genvar c = 0; c < `DILP_NUM_WORDS; c++) begin : g_map
    localparam int B = ((c & 2) << 1) | ((c & 4) >> 1) | ((c & 8) >> 3);
    localparam int L = ((c & 1) != 0) ? (7 - B) : (8 + B);
    assign mapped[c*16 +: 16] = hold_q[255 - 16*L -: 16];
  end

  // sub-column count is 16 / width: one for x16, two for x8, four for x4
  assign mask_x8 = subcolumn_select[3] ? `DILP_MASK_HI8 : `DILP_MASK_LO8;
  assign mask_x4 = `DILP_MASK_Q4 << {subcolumn_select[3:2], 2'b00};
  assign wr_mask = (programmed_width == `DILP_WIDTH_X8) ? mask_x8 :
                   (programmed_width == `DILP_WIDTH_X4) ? mask_x4 : `DILP_MASK_ALL;
  assign commit  = col_wr_valid && column_loaded;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_wr_valid  <= 1'b0;
      core_wr_enable <= 16'h0000;
      core_word      <= '0;
    end else begin
      core_wr_valid <= commit;
      if (commit) begin
        core_wr_enable <= wr_mask;
        core_word      <= mapped;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_chain_seen_low;
    $rose(id_valid);
  endsequence

  sequence s_chain_dropped;
    ##[1:40] !chain_output;
  endsequence

  a_settle_low_power: assert property (settle_hit |=> low_power)
    else $error("low-power state not entered after settle time");
  a_reset_low_power: assert property (reset_edge |=> low_power)
    else $error("serial reset did not enter low-power state");
  a_reset_defaults: assert property (reset_edge |=>
      programmed_width == `DILP_WIDTH_RESET && !column_loaded && !id_valid)
    else $error("control state not at defaults after serial reset");
  a_shift_byte: assert property (take |=>
      hold_q[7:0] == $past(fifo_data) && hold_q[15:8] == $past(hold_q[7:0]))
    else $error("pattern byte not shifted by eight bits");
  a_column_full: assert property (take && byte_cnt_q == `DILP_BYTES_PER_COL |=> column_loaded)
    else $error("column not marked loaded after last byte");
  a_x8_select: assert property (commit && programmed_width == `DILP_WIDTH_X8
      && !subcolumn_select[3] |=> core_wr_valid && core_wr_enable == `DILP_MASK_LO8)
    else $error("x8 low sub-column mask wrong");
  a_word_map: assert property (commit |=>
      core_word[15:0] == $past(hold_q[127:112]) && core_word[255:240] == $past(hold_q[255:240]))
    else $error("loaded word to core word map wrong");
  a_no_commit_empty: assert property (col_wr_valid && !column_loaded |=> !core_wr_valid)
    else $error("commit without a loaded column");
  a_chain_release: assert property (s_chain_seen_low |-> s_chain_dropped)
    else $error("chain output not driven low after chain input low");
  a_id_zero: assert property (release_edge && !chain_s |=> chain_position_id == 6'h00)
    else $error("first device in chain did not take id zero");

endmodule : dilp_top

// >>> tb/dilp_ctrl_model.sv
// controller model driving the serial reset, serial clock and chain input
`timescale 1ns/1ps
module dilp_ctrl_model (
  input  wire logic       start,
  input  wire logic [5:0] chain_pos,
  output logic            serial_clk,
  output logic            serial_reset,
  output logic            chain_input,
  output logic            done
);
  // one 800 ns serial cycle: levels change at the rise, the device samples at the fall
  task automatic sck_cycle(input logic r, input logic c);
    serial_clk   = 1'b1;
    serial_reset = r;
    chain_input  = c;
    #400;
    serial_clk = 1'b0;
    #400;
  endtask : sck_cycle

  // serial clock stands low between frames
  initial begin
    serial_clk   = 1'b0;
    serial_reset = 1'b0;
    chain_input  = 1'b0;
    done         = 1'b0;
    forever begin
      @(posedge start);
      done = 1'b0;
      #37;
      repeat (4) sck_cycle(1'b0, 1'b0);
      repeat (2) sck_cycle(1'b1, 1'b1);
      // upstream device releases the chain chain_pos cycles after reset release
      for (int i = 0; i <= chain_pos + 3; i++) begin
        sck_cycle(1'b0, (i < chain_pos) ? 1'b1 : 1'b0);
      end
      done = 1'b1;
    end
  end
endmodule : dilp_ctrl_model

// >>> tb/testbench.sv
// self-checking testbench for the dram init and pattern-load block
`timescale 1ns/1ps
module testbench;
  import dilp_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         start = 1'b0;
  logic [5:0]   pos = 6'h00;
  logic         serial_clk, serial_reset, chain_input, done;
  logic         chain_output, id_valid, low_power, pattern_ready, column_loaded;
  logic [5:0]   chain_position_id;
  logic [2:0]   programmed_width;
  logic [10:0]  bank_row_counter;
  logic         core_wr_valid;
  logic [15:0]  core_wr_enable;
  logic [255:0] core_word;
  logic         powerdown_exit = 1'b0, width_wr = 1'b0, rai = 1'b0;
  logic         pattern_valid = 1'b0, col_wr_valid = 1'b0;
  logic [2:0]   width_cfg = 3'h4;
  logic [7:0]   pattern_byte = 8'h00;
  logic [3:0]   subcolumn_select = 4'h0;
  int           num_errors = 0;
  int           n_tests = 0;
  int           cyc = 0;

  always #50 core_clk = ~core_clk;

  dilp_ctrl_model ctrl_u (.start(start), .chain_pos(pos), .serial_clk(serial_clk),
    .serial_reset(serial_reset), .chain_input(chain_input), .done(done));

  dilp_top #(.SETTLE_CYCLES(20)) dut_u (.core_clk(core_clk), .rst(rst),
    .serial_clk(serial_clk), .serial_reset(serial_reset), .chain_input(chain_input),
    .chain_output(chain_output), .chain_position_id(chain_position_id),
    .id_valid(id_valid), .low_power(low_power), .powerdown_exit(powerdown_exit),
    .width_wr(width_wr), .width_cfg(width_cfg), .programmed_width(programmed_width),
    .refresh_activate_increment(rai), .bank_row_counter(bank_row_counter),
    .pattern_valid(pattern_valid), .pattern_byte(pattern_byte),
    .pattern_ready(pattern_ready), .column_loaded(column_loaded),
    .col_wr_valid(col_wr_valid), .subcolumn_select(subcolumn_select),
    .core_wr_valid(core_wr_valid), .core_wr_enable(core_wr_enable),
    .core_word(core_word));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic tick();
    @(posedge core_clk);
    #10;
  endtask : tick

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  function automatic logic [7:0] byte_of(input int j);
    return 8'((j * 37 + 5) % 256);
  endfunction : byte_of

  // loaded word feeding each core word, indexed by core word; loaded word L is bytes 2L, 2L+1
  int l_of_c [16] = '{8, 7, 12, 3, 10, 5, 14, 1, 9, 6, 13, 2, 11, 4, 15, 0};

  function automatic logic [15:0] exp_word(input int c);
    int l;
    l = l_of_c[c];
    return {byte_of(2 * l), byte_of(2 * l + 1)};
  endfunction : exp_word

  function automatic logic [15:0] exp_mask(input logic [2:0] w, input logic [3:0] sc);
    if (w == 3'h3) return sc[3] ? 16'hFF00 : 16'h00FF;
    if (w == 3'h2) return 16'h000F << (4 * sc[3:2]);
    return 16'hFFFF;
  endfunction : exp_mask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_settle();
    repeat (18) tick();
    check(low_power === 1'b0, "low power too early");
    repeat (4) tick();
    check(low_power === 1'b1, "no low power after settle");
    powerdown_exit = 1'b1;
    tick();
    powerdown_exit = 1'b0;
    tick();
    check(low_power === 1'b0, "powerdown exit ignored");
  endtask : t_settle

  task automatic t_rows();
    rai = 1'b1;
    repeat (8) tick();
    rai = 1'b0;
    tick();
    check(bank_row_counter === 11'h008, "row counter steps");
  endtask : t_rows

  task automatic t_serial(input logic [5:0] k);
    width_wr = 1'b1;
    width_cfg = 3'h3;
    tick();
    width_wr = 1'b0;
    pos = k;
    start = 1'b1;
    tick();
    start = 1'b0;
    for (int g = 0; g < 1000 && done !== 1'b1; g++) tick();
    repeat (10) tick();
    check(low_power === 1'b1, "serial reset low power");
    check(programmed_width === 3'h4, "width default");
    check(bank_row_counter === 11'h000, "row counter default");
    check(id_valid === 1'b1 && chain_position_id === k, "chain id");
    check(chain_output === 1'b0, "chain output not low");
  endtask : t_serial

  task automatic t_refuse();
    col_wr_valid = 1'b1;
    tick();
    col_wr_valid = 1'b0;
    repeat (2) begin
      tick();
      check(core_wr_valid === 1'b0, "commit without column");
    end
  endtask : t_refuse

  task automatic t_load();
    int j;
    logic rdy;
    logic full_seen;
    j = 0;
    full_seen = 1'b0;
    col_wr_valid = 1'b1;
    for (int g = 0; g < 300 && j < 32; g++) begin
      pattern_valid = 1'b1;
      pattern_byte = byte_of(j);
      rdy = pattern_ready;
      if (rdy !== 1'b1 && col_wr_valid === 1'b1) begin
        check(j == 16, "fifo full count");
        full_seen = 1'b1;
        col_wr_valid = 1'b0;
      end
      tick();
      if (rdy === 1'b1) j++;
    end
    pattern_valid = 1'b0;
    check(full_seen, "fifo never refused");
    for (int g = 0; g < 40 && column_loaded !== 1'b1; g++) tick();
    check(column_loaded === 1'b1, "column not loaded");
  endtask : t_load

  task automatic t_commit(input logic [2:0] w, input logic [3:0] sc);
    logic [15:0] m;
    m = exp_mask(w, sc);
    width_wr = 1'b1;
    width_cfg = w;
    tick();
    width_wr = 1'b0;
    col_wr_valid = 1'b1;
    subcolumn_select = sc;
    tick();
    col_wr_valid = 1'b0;
    for (int g = 0; g < 3 && core_wr_valid !== 1'b1; g++) tick();
    check(core_wr_valid === 1'b1, "no commit");
    check(core_wr_enable === m, "write enables");
    for (int c = 0; c < 16; c++) begin
      if (m[c]) check(core_word[16*c +: 16] === exp_word(c), "core word");
    end
    tick();
    check(core_wr_valid === 1'b0, "commit pulse too long");
  endtask : t_commit

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [2:0] w_tab [8] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h7};
  logic [3:0] s_tab [8] = '{4'h0, 4'h7, 4'h8, 4'h1, 4'h4, 4'hB, 4'hD, 4'h9};

  initial begin
    repeat (10) tick();
    rst = 1'b0;
    t_settle();
    t_rows();
    t_serial(6'h00);
    t_serial(6'h05);
    t_refuse();
    t_load();
    for (int i = 0; i < 8; i++) t_commit(w_tab[i], s_tab[i]);
    final_report();
  end
endmodule : testbench
